// file: design/edp_regs.svh
// Register map, reset values and timing constants of the divided pulse output
`ifndef EDP_REGS_SVH
`define EDP_REGS_SVH
`define EDP_ADDR_CTRL       8'h00
`define EDP_ADDR_PPR        8'h04
`define EDP_ADDR_LIN_RES    8'h08
`define EDP_ADDR_MAX_SPEED  8'h0C
`define EDP_ADDR_PITCH      8'h10
`define EDP_ADDR_STATUS     8'h14
`define EDP_ADDR_MASK       8'h18
`define EDP_ADDR_INFO       8'h1C
`define EDP_CTRL_RESTART    0
`define EDP_CTRL_LINEAR     1
`define EDP_ST_SET_ERR      0
`define EDP_ST_OVERSPEED    1
`define EDP_PPR_DEFAULT     31'h0000_0800
`define EDP_PPR_MIN         31'h0000_0010
`define EDP_PPR_TOP         31'h0040_0000
`define EDP_PPR_BAND0       31'h0000_4000
`define EDP_LIN_DEFAULT     13'h0014
`define EDP_LIN_MAX         13'h1000
`define EDP_SPEED_DEFAULT   16'h0032
`define EDP_PITCH_DEFAULT   20'h007D0
`define EDP_SPEED_BAND0     16'h1770
`define EDP_PITCH_NUM       8'h48
`define EDP_PITCH_DEN       8'h64
`define EDP_BAND_MAX        4'h8
`define EDP_MAX_RATE_HZ     1600000
`define EDP_CLK_HZ          25000000
`define EDP_RES_20          2'h0
`define EDP_RES_22          2'h1
`endif

// file: design/edp_pkg.sv
// Types shared by the divided pulse output block
package edp_pkg;
    typedef struct packed {
        logic step;
        logic dir;
    } edp_enc_t;
    typedef enum logic [1:0] {
        EDP_Q00 = 2'b00,
        EDP_Q01 = 2'b01,
        EDP_Q11 = 2'b11,
        EDP_Q10 = 2'b10
    } edp_quad_t;
    typedef struct packed {
        logic phase_a_out;
        logic phase_a_out_n;
        logic phase_b_out;
        logic phase_b_out_n;
    } edp_phase_t;
endpackage : edp_pkg

// file: design/edp_top.sv
// Encoder divided pulse output with Wishbone register file
// Functional notes
// - Rotary pulse count 16..2^22, default 2048, on restart
// - Rotary output gives exactly configured pulses per rev
// - Rotary setting must sit on its band increment
// - Rotary speed limit 6000 halving per band
// - Bad rotary or linear setting raises setting error
// - Output edge rate held under about 1.6 Mpps
// - Speed above resolution limit raises overspeed alarm
// - Drive phases A, B and both complements
// - Linear edges per pitch 1..4096, default 20
// - Linear: feedback per pitch times 4, divided
// - Linear setting invalid above pitch/100/speed*72
// - Without converter, detected pitch replaces configured pitch
//
// Our own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`include "edp_regs.svh"
module edp_top
    import edp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire edp_enc_t    enc_in,
    input  wire logic [1:0]  enc_res_sel,
    input  wire logic [15:0] lin_fb_per_pitch,
    input  wire logic        converter_present,
    input  wire logic [19:0] detected_pitch,
    input  wire logic [15:0] motor_speed,
    output edp_phase_t       phase_out,
    output logic             irq
);
    localparam int GAP_CYC =
        (`EDP_CLK_HZ + `EDP_MAX_RATE_HZ - 1) / `EDP_MAX_RATE_HZ;
    localparam logic [4:0] GAP_LOAD = 5'(GAP_CYC - 1);

    // Band index: 0 up to 16384, one more per doubling above it
    function automatic logic [3:0] band_of(input logic [30:0] ppr);
        logic [3:0] b;
        b = 4'h0;
        for (int i = 1; i <= 8; i++) begin
            if (ppr > (`EDP_PPR_BAND0 << (i - 1))) begin
                b = 4'(i);
            end
        end
        return b;
    endfunction : band_of

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    // Software-visible registers; mask_reg acts at once, pitch_reg at once for overspeed, the rest only on restart
    logic [30:0] ppr_reg;
    logic [12:0] lin_res_reg;
    logic [15:0] max_speed_reg;
    logic [19:0] pitch_reg;
    logic        linear_reg;
    logic [1:0]  mask_reg;
    logic [1:0]  status_reg;
    // Applied copies
    logic [30:0] act_ppr_reg;
    logic [12:0] act_lin_reg;
    logic [15:0] act_speed_reg;
    logic        act_linear_reg;
    logic        restart_reg;
    logic        set_err_reg;
    logic        overspeed_reg;
    logic [25:0] acc_reg;
    logic [7:0]  backlog_reg;
    logic [4:0]  gap_reg;
    edp_quad_t   quad_reg;

    logic        wb_hit;
    logic        wr;
    logic        rd_status;
    logic [31:0] cur;
    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = wb_hit && wb_we_i;
    assign rd_status = wb_hit && !wb_we_i && wb_adr_i == `EDP_ADDR_STATUS;

    // Byte-merged write value of the addressed register
    always_comb begin
        case (wb_adr_i)
            `EDP_ADDR_CTRL:
                cur = merge({30'h0, linear_reg, 1'b0}, wb_dat_i, wb_sel_i);
            `EDP_ADDR_PPR:
                cur = merge({1'b0, ppr_reg}, wb_dat_i, wb_sel_i);
            `EDP_ADDR_LIN_RES:
                cur = merge({19'h0, lin_res_reg}, wb_dat_i, wb_sel_i);
            `EDP_ADDR_MAX_SPEED:
                cur = merge({16'h0, max_speed_reg}, wb_dat_i, wb_sel_i);
            `EDP_ADDR_PITCH:
                cur = merge({12'h0, pitch_reg}, wb_dat_i, wb_sel_i);
            `EDP_ADDR_MASK:
                cur = merge({30'h0, mask_reg}, wb_dat_i, wb_sel_i);
            default:
                cur = 32'h0;
        endcase
    end

    // Register writes
    always_ff @(posedge clk) begin
        restart_reg <= 1'b0;
        if (srst) begin
            ppr_reg       <= `EDP_PPR_DEFAULT;
            lin_res_reg   <= `EDP_LIN_DEFAULT;
            max_speed_reg <= `EDP_SPEED_DEFAULT;
            pitch_reg     <= `EDP_PITCH_DEFAULT;
            linear_reg    <= 1'b0;
            mask_reg      <= 2'h0;
        end else if (wr) begin
            case (wb_adr_i)
                `EDP_ADDR_CTRL: begin
                    linear_reg  <= cur[`EDP_CTRL_LINEAR];
                    restart_reg <= cur[`EDP_CTRL_RESTART];
                end
                `EDP_ADDR_PPR:       ppr_reg       <= cur[30:0];
                `EDP_ADDR_LIN_RES:   lin_res_reg   <= cur[12:0];
                `EDP_ADDR_MAX_SPEED: max_speed_reg <= cur[15:0];
                `EDP_ADDR_PITCH:     pitch_reg     <= cur[19:0];
                `EDP_ADDR_MASK:      mask_reg      <= cur[1:0];
                default: begin
                end
            endcase
        end
    end

    // Setting checks over the shadow values
    logic [3:0]  band;
    logic [4:0]  enc_bits;
    logic [30:0] rot_cap;
    logic        rot_ok;
    logic [19:0] eff_pitch;
    logic [35:0] lin_lhs;
    logic [27:0] lin_rhs;
    logic        lin_ok;
    logic [30:0] step_mask;
    always_comb begin
        band      = band_of(ppr_reg);
        step_mask = (31'h1 << band) - 31'h1;
        enc_bits  = (enc_res_sel == `EDP_RES_20) ? 5'd20 :
                    (enc_res_sel == `EDP_RES_22) ? 5'd22 : 5'd24;
        rot_cap   = 31'h1 << (enc_bits - 5'd2);
        rot_ok    = ppr_reg >= `EDP_PPR_MIN && ppr_reg <= `EDP_PPR_TOP
                    && (ppr_reg & step_mask) == 31'h0
                    && ppr_reg <= rot_cap;
        eff_pitch = converter_present ? pitch_reg : detected_pitch;
        lin_lhs   = 36'(lin_res_reg) * 36'(max_speed_reg)
                    * 36'(`EDP_PITCH_DEN);
        lin_rhs   = 28'(eff_pitch) * 28'(`EDP_PITCH_NUM);
        lin_ok    = lin_res_reg != 13'h0 && lin_res_reg <= `EDP_LIN_MAX
                    && lin_lhs <= 36'(lin_rhs);
    end

    // Restart applies settings; reset acts as a restart with defaults
    always_ff @(posedge clk) begin
        if (srst) begin
            act_ppr_reg    <= `EDP_PPR_DEFAULT;
            act_lin_reg    <= `EDP_LIN_DEFAULT;
            act_speed_reg  <= `EDP_SPEED_BAND0;
            act_linear_reg <= 1'b0;
            set_err_reg    <= 1'b0;
        end else if (restart_reg) begin
            act_ppr_reg    <= ppr_reg;
            act_lin_reg    <= lin_res_reg;
            act_linear_reg <= linear_reg;
            set_err_reg    <= linear_reg ? !lin_ok : !rot_ok;
            act_speed_reg  <= `EDP_SPEED_BAND0 >> band;
        end
    end

    // Overspeed: rotary against band limit, linear against pitch formula
    logic [35:0] spd_lhs;
    logic        over_now;
    always_comb begin
        spd_lhs  = 36'(act_lin_reg) * 36'(motor_speed)
                   * 36'(`EDP_PITCH_DEN);
        over_now = act_linear_reg ? (spd_lhs > 36'(lin_rhs))
                                  : (motor_speed > act_speed_reg);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            overspeed_reg <= 1'b0;
        end else begin
            overspeed_reg <= over_now;
        end
    end

    // Sticky status; a read clears, but a new event in that cycle wins
    logic [1:0] events;
    assign events = {over_now && !overspeed_reg,
                     restart_reg && (linear_reg ? !lin_ok : !rot_ok)};
    always_ff @(posedge clk) begin
        if (srst) begin
            status_reg <= 2'h0;
        end else begin
            status_reg <= (rd_status ? 2'h0 : status_reg) | events;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_reg & mask_reg);
        end
    end

    // Fractional divider: one output edge per modulus crossing
    logic [26:0] inc;
    logic [26:0] modulus;
    logic [26:0] sum;
    logic        fwd_edge;
    logic        rev_edge;
    logic [25:0] acc_next;
    always_comb begin
        inc      = act_linear_reg ? 27'(act_lin_reg)
                                  : 27'({act_ppr_reg, 2'b00});
        modulus  = act_linear_reg ? 27'({lin_fb_per_pitch, 2'b00})
                                  : (27'h1 << enc_bits);
        fwd_edge = 1'b0;
        rev_edge = 1'b0;
        acc_next = acc_reg;
        sum      = 27'h0;
        if (enc_in.step && !set_err_reg && modulus != 27'h0) begin
            if (!enc_in.dir) begin
                sum = 27'(acc_reg) + inc;
                if (sum >= modulus) begin
                    fwd_edge = 1'b1;
                    sum      = sum - modulus;
                end
            end else begin
                sum = 27'(acc_reg) + modulus - inc;
                if (27'(acc_reg) < inc) begin
                    rev_edge = 1'b1;
                end else begin
                    sum = sum - modulus;
                end
            end
            acc_next = sum[25:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst || restart_reg) begin
            acc_reg <= 26'h0;
        end else begin
            acc_reg <= acc_next;
        end
    end

    // Edge backlog paced by a gap counter keeps the edge rate bounded
    logic emit;
    logic emit_rev;
    assign emit     = gap_reg == 5'h0 && backlog_reg != 8'h0;
    assign emit_rev = backlog_reg[7];
    always_ff @(posedge clk) begin
        if (srst || restart_reg) begin
            backlog_reg <= 8'h0;
            gap_reg     <= 5'h0;
        end else begin
            // Saturation loses edges; overspeed already flags this case
            if (fwd_edge && !emit_rev && backlog_reg != 8'h7F) begin
                backlog_reg <= backlog_reg + 8'h1 - (emit ? 8'h1 : 8'h0);
            end else if (fwd_edge && emit_rev) begin
                backlog_reg <= backlog_reg + 8'h1 + (emit ? 8'h1 : 8'h0);
            end else if (rev_edge && emit_rev && backlog_reg != 8'h81) begin
                backlog_reg <= backlog_reg - 8'h1 + (emit ? 8'h1 : 8'h0);
            end else if (rev_edge && !emit_rev) begin
                backlog_reg <= backlog_reg - 8'h1 - (emit ? 8'h1 : 8'h0);
            end else if (emit) begin
                backlog_reg <= emit_rev ? backlog_reg + 8'h1
                                        : backlog_reg - 8'h1;
            end
            if (emit) begin
                gap_reg <= GAP_LOAD;
            end else if (gap_reg != 5'h0) begin
                gap_reg <= gap_reg - 5'h1;
            end
        end
    end

    // Forward: A leads B; reverse: B leads A
    always_ff @(posedge clk) begin
        if (srst) begin
            quad_reg <= EDP_Q00;
        end else if (emit) begin
            case (quad_reg)
                EDP_Q00: quad_reg <= emit_rev ? EDP_Q01 : EDP_Q10;
                EDP_Q10: quad_reg <= emit_rev ? EDP_Q00 : EDP_Q11;
                EDP_Q11: quad_reg <= emit_rev ? EDP_Q10 : EDP_Q01;
                EDP_Q01: quad_reg <= emit_rev ? EDP_Q11 : EDP_Q00;
                default: quad_reg <= EDP_Q00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            phase_out <= '{1'b0, 1'b1, 1'b0, 1'b1};
        end else begin
            phase_out.phase_a_out   <= quad_reg[1];
            phase_out.phase_a_out_n <= !quad_reg[1];
            phase_out.phase_b_out   <= quad_reg[0];
            phase_out.phase_b_out_n <= !quad_reg[0];
        end
    end

    // Wishbone slave: ack one cycle after the strobe, then drop
    always_ff @(posedge clk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_hit;
            if (wb_hit && !wb_we_i) begin
                case (wb_adr_i)
                    `EDP_ADDR_CTRL:      wb_dat_o <= {30'h0, linear_reg, 1'b0};
                    `EDP_ADDR_PPR:       wb_dat_o <= {1'b0, ppr_reg};
                    `EDP_ADDR_LIN_RES:   wb_dat_o <= {19'h0, lin_res_reg};
                    `EDP_ADDR_MAX_SPEED: wb_dat_o <= {16'h0, max_speed_reg};
                    `EDP_ADDR_PITCH:     wb_dat_o <= {12'h0, pitch_reg};
                    `EDP_ADDR_STATUS:    wb_dat_o <= {30'h0, status_reg};
                    `EDP_ADDR_MASK:      wb_dat_o <= {30'h0, mask_reg};
                    `EDP_ADDR_INFO:      wb_dat_o <= {act_speed_reg, 13'h0,
                                                      act_linear_reg,
                                                      overspeed_reg,
                                                      set_err_reg};
                    default:             wb_dat_o <= 32'h0;
                endcase
            end
        end
    end
endmodule : edp_top

// file: bench/edp_props.sv
// Concurrent checks on the divided pulse output ports
`timescale 1ns/1ps
`include "edp_regs.svh"
module edp_props
    import edp_pkg::*;
(
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire edp_phase_t  phase_out,
    input wire logic        irq
);
    logic [1:0] ab;
    logic [1:0] ab_reg;
    logic [4:0] gap_reg;
    logic       moved;
    assign ab    = {phase_out.phase_a_out, phase_out.phase_b_out};
    assign moved = ab != ab_reg;
    // Saturating, so a long idle stretch cannot wrap into a short gap
    always_ff @(posedge clk) begin
        if (srst) begin
            ab_reg  <= 2'h0;
            gap_reg <= 5'h1F;
        end else begin
            ab_reg <= ab;
            if (moved)
                gap_reg <= 5'h00;
            else if (gap_reg != 5'h1F)
                gap_reg <= gap_reg + 5'h01;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    chk_ack_latency: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered in one cycle");
    chk_ack_cause: assert property (
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    chk_reset_idle: assert property (
        $fell(srst) |-> !wb_ack_o && !irq && ab == 2'h0)
        else $error("outputs not idle after reset");
    chk_phase_pairs: assert property (
        phase_out.phase_a_out_n == !phase_out.phase_a_out &&
        phase_out.phase_b_out_n == !phase_out.phase_b_out)
        else $error("complement output mismatch");
    chk_quad_step: assert property (
        moved |-> $countones(ab ^ ab_reg) == 1)
        else $error("both phases moved at once");
    chk_edge_gap: assert property (moved |-> gap_reg >= 5'h0F)
        else $error("phase edges closer than allowed");
    chk_unmapped_zero: assert property (
        wb_ack_o && $past(!wb_we_i && wb_adr_i > 8'h1C) |-> wb_dat_o == 0)
        else $error("unmapped read not zero");
    chk_restart_reads: assert property (
        wb_ack_o && $past(!wb_we_i && wb_adr_i == `EDP_ADDR_CTRL)
        |-> !wb_dat_o[`EDP_CTRL_RESTART])
        else $error("restart bit reads back set");
    cov_irq: cover property ($rose(irq));
    cov_move: cover property (moved && ab == 2'h2);
    cov_write: cover property (wb_ack_o && $past(wb_we_i));
endmodule : edp_props
bind edp_top edp_props edp_props_i (
    .clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .phase_out(phase_out), .irq(irq));

// file: bench/edp_host_model.sv
// Host side quadrature counter watching the phase outputs
`timescale 1ns/1ps
module edp_host_model
    import edp_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          srst,
    input  wire edp_phase_t    phase_out,
    output logic signed [31:0] edge_cnt,
    output logic               bad_step
);
    logic [1:0] cur;
    logic [1:0] prev_reg;
    assign cur = {phase_out.phase_a_out, phase_out.phase_b_out};
    // A skipped state is flagged rather than guessed at
    always_ff @(posedge clk) begin
        if (srst) begin
            prev_reg <= 2'h0;
            edge_cnt <= 32'sh0;
            bad_step <= 1'b0;
        end else begin
            prev_reg <= cur;
            if (cur == {~prev_reg[0], prev_reg[1]})
                edge_cnt <= edge_cnt + 32'sh1;
            else if (cur == {prev_reg[0], ~prev_reg[1]})
                edge_cnt <= edge_cnt - 32'sh1;
            else if (cur != prev_reg)
                bad_step <= 1'b1;
            if (phase_out.phase_a_out_n == phase_out.phase_a_out)
                bad_step <= 1'b1;
        end
    end
endmodule : edp_host_model

// file: bench/edp_tb.sv
// Self-checking bench for the divided pulse output block
`timescale 1ns/1ps
`include "edp_regs.svh"
`define TB_CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
    err_count++; $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module testbench
    import edp_pkg::*;
;
    logic               clk, srst, cyc, stb, we, ack, irq, conv, bad;
    logic [7:0]         adr;
    logic [3:0]         sel;
    logic [31:0]        wd, rdat, q;
    logic [1:0]         rsel;
    logic [15:0]        fb, spd;
    logic [19:0]        dp;
    logic signed [31:0] cnt;
    edp_enc_t           enc;
    edp_phase_t         ph;
    int                 err_count, checks_done;
    edp_top edp_top_i (.clk(clk), .srst(srst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .enc_in(enc),
        .enc_res_sel(rsel), .lin_fb_per_pitch(fb),
        .converter_present(conv), .detected_pitch(dp), .motor_speed(spd),
        .phase_out(ph), .irq(irq));
    edp_host_model edp_host_model_i (.clk(clk), .srst(srst),
        .phase_out(ph), .edge_cnt(cnt), .bad_step(bad));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, wd} <= {2'h3, w, a, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        {cyc, stb} <= 2'h0;
        if (n >= 20) `TB_CHK(n, 0)
    endtask : wb
    task automatic rd(input logic [7:0] a);
        wb(1'b0, a, 32'h0);
    endtask : rd
    // Settings other than the mask and pitch only take hold here, never on the register write itself
    task automatic go(input logic lin);
        wb(1'b1, `EDP_ADDR_CTRL, {30'h0, lin, 1'b1});
        repeat (5) @(posedge clk);
    endtask : go
    task automatic steps(input int n, input logic d);
        repeat (n) begin
            @(posedge clk);
            enc <= '{1'b1, d};
            @(posedge clk);
            enc.step <= 1'b0;
            repeat (18) @(posedge clk);
        end
    endtask : steps
    task automatic edges(input logic signed [31:0] n);
        int k;
        k = 0;
        while (cnt !== n && k < 4000) begin
            @(posedge clk);
            k++;
        end
        repeat (40) @(posedge clk);
        `TB_CHK(cnt, n)
        `TB_CHK(bad, 1'b0)
    endtask : edges
    task automatic t_defaults;
        `TB_CHK(ph, 4'h5)
        rd(`EDP_ADDR_PPR);
        `TB_CHK(q, 32'h800)
        rd(`EDP_ADDR_LIN_RES);
        `TB_CHK(q, 32'h14)
        rd(8'h20);
        `TB_CHK(q, 32'h0)
    endtask : t_defaults
    task automatic t_bands;
        rsel <= 2'h2;
        for (int k = 0; k < 9; k++) begin
            wb(1'b1, `EDP_ADDR_PPR, 32'h4000 << k);
            rd(`EDP_ADDR_INFO);
            `TB_CHK(q[31:16], 16'h1770 >> (k > 0 ? k - 1 : 0))
            go(1'b0);
            rd(`EDP_ADDR_INFO);
            `TB_CHK(q[31:16], 16'h1770 >> k)
            `TB_CHK(q[0], 1'b0)
        end
    endtask : t_bands
    task automatic t_errors;
        logic [31:0] pv [9] = '{32'hF, 32'h10, 32'h61A8, 32'h61A9,
            32'h4001, 32'h400001, 32'h80040, 32'h80040, 32'h100080};
        logic [1:0]  rv [9] = '{2'h2, 2'h0, 2'h2, 2'h2, 2'h2, 2'h2,
            2'h0, 2'h1, 2'h1};
        logic [8:0]  ev = 9'h179;
        int          b;
        wb(1'b1, `EDP_ADDR_MASK, 32'h1);
        for (int i = 0; i < 9; i++) begin
            rsel <= rv[i];
            wb(1'b1, `EDP_ADDR_PPR, pv[i]);
            go(1'b0);
            `TB_CHK(irq, ev[i])
            rd(`EDP_ADDR_STATUS);
            `TB_CHK(q[0], ev[i])
            rd(`EDP_ADDR_STATUS);
            `TB_CHK(q[0], 1'b0)
        end
        b = cnt;
        steps(8, 1'b0);
        repeat (40) @(posedge clk);
        `TB_CHK(cnt, b)
        `TB_CHK(irq, 1'b0)
    endtask : t_errors
    task automatic t_rotary;
        int b;
        rsel <= 2'h0;
        spd <= 16'h64;
        wb(1'b1, `EDP_ADDR_PPR, 32'h40000);
        go(1'b0);
        b = cnt;
        steps(64, 1'b0);
        edges(b + 64);
        steps(32, 1'b1);
        edges(b + 32);
        wb(1'b1, `EDP_ADDR_PPR, 32'h20000);
        go(1'b0);
        b = cnt;
        steps(64, 1'b0);
        edges(b + 32);
    endtask : t_rotary
    task automatic t_linear;
        logic [12:0] rv [6] = '{13'h1C, 13'h1D, 13'h1D, 13'h1000,
            13'h1001, 13'h0};
        logic [15:0] sv [6] = '{16'h32, 16'h32, 16'h32, 16'h1, 16'h1,
            16'h1};
        logic [5:0]  cv = 6'h03;
        logic [5:0]  ev = 6'h32;
        int          b;
        {dp, spd} <= {20'h01770, 16'h0};
        wb(1'b1, `EDP_ADDR_LIN_RES, 32'hA);
        go(1'b1);
        b = cnt;
        steps(40, 1'b0);
        edges(b + 20);
        for (int i = 0; i < 6; i++) begin
            conv <= cv[i];
            wb(1'b1, `EDP_ADDR_MAX_SPEED, {16'h0, sv[i]});
            wb(1'b1, `EDP_ADDR_LIN_RES, {19'h0, rv[i]});
            go(1'b1);
            rd(`EDP_ADDR_STATUS);
            `TB_CHK(q[0], ev[i])
        end
    endtask : t_linear
    task automatic t_overspeed;
        rsel <= 2'h2;
        wb(1'b1, `EDP_ADDR_PPR, 32'h800);
        go(1'b0);
        wb(1'b1, `EDP_ADDR_MASK, 32'h2);
        spd <= 16'h1770;
        rd(`EDP_ADDR_STATUS);
        rd(`EDP_ADDR_STATUS);
        `TB_CHK(q[1], 1'b0)
        spd <= 16'h1771;
        repeat (5) @(posedge clk);
        `TB_CHK(irq, 1'b1)
        rd(`EDP_ADDR_INFO);
        `TB_CHK(q[1], 1'b1)
        rd(`EDP_ADDR_STATUS);
        `TB_CHK(q[1], 1'b1)
    endtask : t_overspeed
    task automatic print_verdict;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    initial begin
        {srst, cyc, stb, we, adr, sel, wd} = {4'h8, 8'h0, 4'hF, 32'h0};
        {rsel, fb, conv, dp, spd} = {2'h0, 16'h5, 1'b1, 20'h0, 16'h0};
        enc = '0;
        err_count = 0;
        checks_done = 0;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        t_defaults;
        t_bands;
        t_errors;
        t_rotary;
        t_linear;
        t_overspeed;
        print_verdict;
    end
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        print_verdict;
    end
endmodule : testbench
